// ===== design/pcac_defines.svh
`ifndef PCAC_DEFINES_SVH
`define PCAC_DEFINES_SVH

// ----------------------------------------
// Clock, line and gain control timing
// ----------------------------------------
`define PCAC_CLK_MHZ 40
`define PCAC_SHUTDOWN_DELAY_US 300
`define PCAC_DATA_VALID_US 300
`define PCAC_WAKE_UP_US 500
`define PCAC_ATTACK_INTERVAL_US 64
`define PCAC_HOLD_INTERVAL_US 512
`define PCAC_RELEASE_INTERVAL_US 256

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PCAC_STATUS_OFF 8'h00
`define PCAC_CTRL_OFF 8'h04
`define PCAC_LAST_COUNT_OFF 8'h08

// ----------------------------------------
// Status field positions
// ----------------------------------------
`define PCAC_ST_CFG_LSB 0
`define PCAC_ST_ATTEN_LSB 9
`define PCAC_ST_AWAKE_BIT 13
`define PCAC_ST_HIZ_BIT 14
`define PCAC_ST_SHUT_BIT 15

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PCAC_CFG_DEFAULT 9'h1c7
`define PCAC_MAX_ATTEN_RESET 4'hf

`endif

// ===== design/pcac_pkg.sv
package pcac_pkg;

  localparam int PCAC_TW = 20;

  typedef enum logic [1:0] {
    PCAC_AWAKE,
    PCAC_SHUT,
    PCAC_WAKE
  } pcac_mode_t;

  // Amplifier configuration as set from the control line.
  typedef struct packed {
    logic agc_en;
    logic limit_en;
    logic gain18;
    logic [2:0] thd;
    logic [2:0] plim;
  } pcac_cfg_t;

  typedef struct packed {
    pcac_mode_t mode;
    logic line_prev;
    logic [5:0] pulse_cnt;
    logic [PCAC_TW-1:0] hi_cnt;
    logic [PCAC_TW-1:0] lo_cnt;
    logic [PCAC_TW-1:0] wake_cnt;
    pcac_cfg_t cfg;
    logic [5:0] last_count;
    logic [3:0] atten;
    logic [3:0] max_atten;
    logic [PCAC_TW-1:0] since_dec;
    logic [PCAC_TW-1:0] since_inc;
    logic bridge_hiz;
    logic amp_on;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pcac_state_t;

endpackage

// ===== design/pcac_top.sv
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`include "pcac_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module pcac_top
  import pcac_pkg::*;
#(
  parameter int unsigned SD_CYC = `PCAC_SHUTDOWN_DELAY_US * `PCAC_CLK_MHZ,
  parameter int unsigned VALID_CYC = `PCAC_DATA_VALID_US * `PCAC_CLK_MHZ,
  parameter int unsigned WAKE_CYC = `PCAC_WAKE_UP_US * `PCAC_CLK_MHZ,
  parameter int unsigned ATTACK_CYC = `PCAC_ATTACK_INTERVAL_US * `PCAC_CLK_MHZ,
  parameter int unsigned HOLD_CYC = `PCAC_HOLD_INTERVAL_US * `PCAC_CLK_MHZ,
  parameter int unsigned RELEASE_CYC = `PCAC_RELEASE_INTERVAL_US * `PCAC_CLK_MHZ
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic config_line_in,
  input wire logic clip_near_in,
  input wire logic headroom_in,
  input wire logic over_current_in,
  output logic agc_en_out,
  output logic limit_en_out,
  output logic gain18_out,
  output logic [2:0] thd_sel_out,
  output logic [2:0] plim_sel_out,
  output logic [3:0] atten_out,
  output logic amp_on_out,
  output logic bridge_hiz_out,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam logic [PCAC_TW-1:0] SD_L = PCAC_TW'(SD_CYC);
  localparam logic [PCAC_TW-1:0] VALID_L = PCAC_TW'(VALID_CYC);
  localparam logic [PCAC_TW-1:0] WAKE_L = PCAC_TW'(WAKE_CYC);
  localparam logic [PCAC_TW-1:0] ATT_L = PCAC_TW'(ATTACK_CYC);
  localparam logic [PCAC_TW-1:0] HOLD_L = PCAC_TW'(HOLD_CYC);
  localparam logic [PCAC_TW-1:0] REL_L = PCAC_TW'(RELEASE_CYC);
  localparam pcac_cfg_t CFG_DEF = pcac_cfg_t'(`PCAC_CFG_DEFAULT);

  pcac_state_t s;
  pcac_state_t next_s;
  logic rise;
  logic apply_now;

  // ----------------------------------------
  // Line edge and apply strobe
  // ----------------------------------------
  assign rise = config_line_in && !s.line_prev;
  assign apply_now = (s.mode == PCAC_AWAKE) && config_line_in && s.line_prev &&
                     (s.hi_cnt == VALID_L) && (s.pulse_cnt != 6'h00);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [31:0] rd;
    rd = 32'h0000_0000;
    next_s = s;
    next_s.line_prev = config_line_in;

    unique case (s.mode)
      PCAC_AWAKE: begin
        if (config_line_in) begin
          next_s.lo_cnt = '0;
          if (rise) begin
            if (s.pulse_cnt != 6'h3f) begin
              next_s.pulse_cnt = s.pulse_cnt + 6'h01;
            end
            next_s.hi_cnt = '0;
          end else if (s.hi_cnt < VALID_L) begin
            next_s.hi_cnt = s.hi_cnt + 1'b1;
          end
        end else begin
          next_s.hi_cnt = '0;
          if (s.lo_cnt == SD_L - 1'b1) begin
            next_s.mode = PCAC_SHUT;
            next_s.pulse_cnt = 6'h00;
            next_s.lo_cnt = '0;
          end else begin
            next_s.lo_cnt = s.lo_cnt + 1'b1;
          end
        end
      end
      PCAC_SHUT: begin
        if (rise) begin
          next_s.mode = PCAC_WAKE;
          next_s.wake_cnt = '0;
        end
      end
      PCAC_WAKE: begin
        if (s.wake_cnt == WAKE_L - 1'b1) begin
          next_s.mode = PCAC_AWAKE;
          next_s.cfg = CFG_DEF;
          next_s.hi_cnt = '0;
          next_s.lo_cnt = '0;
          next_s.pulse_cnt = 6'h00;
        end else begin
          next_s.wake_cnt = s.wake_cnt + 1'b1;
        end
      end
      default: begin
        next_s.mode = PCAC_SHUT;
      end
    endcase

    // Pulse counts outside 1..23 fall through every branch.
    if (apply_now) begin
      next_s.pulse_cnt = 6'h00;
      next_s.last_count = s.pulse_cnt;
      if (s.pulse_cnt == 6'h01) begin
        next_s.cfg.agc_en = 1'b0;
      end else if (s.pulse_cnt == 6'h02) begin
        next_s.cfg.agc_en = 1'b1;
      end else if (s.pulse_cnt == 6'h03) begin
        next_s.cfg = CFG_DEF;
      end else if (s.pulse_cnt == 6'h04) begin
        next_s.cfg.gain18 = 1'b0;
      end else if (s.pulse_cnt == 6'h05) begin
        next_s.cfg.gain18 = 1'b1;
      end else if (s.pulse_cnt <= 6'h0d) begin
        next_s.cfg.thd = 3'(s.pulse_cnt - 6'h06);
      end else if (s.pulse_cnt == 6'h0e) begin
        next_s.cfg.limit_en = 1'b1;
      end else if (s.pulse_cnt == 6'h0f) begin
        next_s.cfg.limit_en = 1'b0;
      end else if (s.pulse_cnt <= 6'h17) begin
        next_s.cfg.plim = 3'(s.pulse_cnt - 6'h10);
      end
    end

    // Gain control: atten counts gain steps removed from the amplifier.
    if (s.since_dec != '1) begin
      next_s.since_dec = s.since_dec + 1'b1;
    end
    if (s.since_inc != '1) begin
      next_s.since_inc = s.since_inc + 1'b1;
    end
    if (!next_s.cfg.agc_en || (next_s.mode != PCAC_AWAKE)) begin
      next_s.atten = 4'h0;
    end else if (clip_near_in && (s.atten < s.max_atten) && (s.since_dec >= ATT_L)) begin
      next_s.atten = s.atten + 4'h1;
      next_s.since_dec = '0;
    end else if (!clip_near_in && headroom_in && (s.atten != 4'h0) &&
                 (s.since_dec >= HOLD_L) && (s.since_inc >= REL_L)) begin
      next_s.atten = s.atten - 4'h1;
      next_s.since_inc = '0;
    end

    next_s.bridge_hiz = over_current_in || (next_s.mode != PCAC_AWAKE);
    next_s.amp_on = (next_s.mode == PCAC_AWAKE);

    // ----------------------------------------
    // AXI4-Lite write
    // ----------------------------------------
    if (s.awready && s_axi_awvalid) begin
      next_s.aw_got = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid) begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb0 = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = 2'h0;
      if (s.aw_addr[7:2] == 6'(`PCAC_CTRL_OFF >> 2)) begin
        if (s.wstrb0) begin
          next_s.max_atten = s.wdata[3:0];
        end
      end else if ((s.aw_addr[7:2] != 6'(`PCAC_STATUS_OFF >> 2)) &&
                   (s.aw_addr[7:2] != 6'(`PCAC_LAST_COUNT_OFF >> 2))) begin
        next_s.bresp = 2'h2;
      end
    end
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready = !next_s.w_got && !next_s.bvalid;

    // ----------------------------------------
    // AXI4-Lite read
    // ----------------------------------------
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s.arready && s_axi_arvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = 2'h0;
      if (s_axi_araddr[7:2] == 6'(`PCAC_STATUS_OFF >> 2)) begin
        rd[`PCAC_ST_CFG_LSB +: 9] = s.cfg;
        rd[`PCAC_ST_ATTEN_LSB +: 4] = s.atten;
        rd[`PCAC_ST_AWAKE_BIT] = (s.mode == PCAC_AWAKE);
        rd[`PCAC_ST_HIZ_BIT] = s.bridge_hiz;
        rd[`PCAC_ST_SHUT_BIT] = (s.mode == PCAC_SHUT);
      end else if (s_axi_araddr[7:2] == 6'(`PCAC_CTRL_OFF >> 2)) begin
        rd[3:0] = s.max_atten;
      end else if (s_axi_araddr[7:2] == 6'(`PCAC_LAST_COUNT_OFF >> 2)) begin
        rd[5:0] = s.last_count;
      end else begin
        next_s.rresp = 2'h2;
      end
      next_s.rdata = rd;
    end
    next_s.arready = !next_s.rvalid;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      s <= '0;
      s.mode <= PCAC_AWAKE;
      s.line_prev <= 1'b1;
      s.amp_on <= 1'b1;
      s.cfg <= CFG_DEF;
      s.max_atten <= `PCAC_MAX_ATTEN_RESET;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign agc_en_out = s.cfg.agc_en;
  assign limit_en_out = s.cfg.limit_en;
  assign gain18_out = s.cfg.gain18;
  assign thd_sel_out = s.cfg.thd;
  assign plim_sel_out = s.cfg.plim;
  assign atten_out = s.atten;
  assign amp_on_out = s.amp_on;
  assign bridge_hiz_out = s.bridge_hiz;
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  a_wake_defaults: assert property (
    $past(s.mode) == PCAC_WAKE && s.mode == PCAC_AWAKE |-> s.cfg == CFG_DEF
  ) else $error("defaults not restored at wake-up");

  a_agc_switch: assert property (
    apply_now && s.pulse_cnt <= 6'h02 |=> s.cfg.agc_en == $past(s.pulse_cnt[1])
  ) else $error("gain control count not applied");

  a_thd_select: assert property (
    apply_now && s.pulse_cnt >= 6'h06 && s.pulse_cnt <= 6'h0d
    |=> s.cfg.thd == 3'($past(s.pulse_cnt) - 6'h06)
  ) else $error("distortion target mismatch");

  a_limit_mode: assert property (
    apply_now && (s.pulse_cnt == 6'h0e || s.pulse_cnt == 6'h0f)
    |=> s.cfg.limit_en == !$past(s.pulse_cnt[0])
  ) else $error("power limit mode mismatch");

  a_plim_select: assert property (
    apply_now && s.pulse_cnt >= 6'h10 && s.pulse_cnt <= 6'h17
    |=> s.cfg.plim == 3'($past(s.pulse_cnt) - 6'h10)
  ) else $error("peak limit mismatch");

  a_gain_drop_cause: assert property (
    s.atten > $past(s.atten) |-> $past(clip_near_in) && s.cfg.agc_en
  ) else $error("gain dropped without cause");

  a_attack_gap: assert property (
    s.atten > $past(s.atten) |-> $past(s.since_dec) >= ATT_L
  ) else $error("gain reductions too close");

  a_hold_gap: assert property (
    s.cfg.agc_en && s.mode == PCAC_AWAKE && s.atten < $past(s.atten)
    |-> $past(s.since_dec) >= HOLD_L
  ) else $error("gain raised inside hold interval");

  a_release_gap: assert property (
    s.cfg.agc_en && s.mode == PCAC_AWAKE && s.atten < $past(s.atten)
    |-> $past(s.since_inc) >= REL_L
  ) else $error("gain increases too close");

  a_bridge_hiz: assert property (
    over_current_in |=> bridge_hiz_out
  ) else $error("bridge not high impedance on over-current");

  a_bridge_recover: assert property (
    !over_current_in && next_s.mode == PCAC_AWAKE |=> !bridge_hiz_out
  ) else $error("bridge did not recover");

  a_shutdown_entry: assert property (
    s.mode == PCAC_AWAKE ##1 s.mode == PCAC_SHUT
    |-> $past(s.lo_cnt) == SD_L - 1'b1 && !$past(config_line_in)
  ) else $error("shutdown entered at wrong time");

  a_wake_bound: assert property (
    s.mode == PCAC_WAKE |-> s.wake_cnt < WAKE_L
  ) else $error("wake-up overran its bound");

  a_count_clear: assert property (
    apply_now |=> s.pulse_cnt == 6'h00 && s.last_count == $past(s.pulse_cnt)
  ) else $error("pulse count not applied and cleared");

  a_ignore_count: assert property (
    apply_now && s.pulse_cnt > 6'h17 |=> $stable(s.cfg)
  ) else $error("out-of-range count changed configuration");

endmodule

`default_nettype wire

// ===== sim/pcac_host.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Host side of the control line
// ----------------------------------------
module pcac_host (
  input wire logic clk_in,
  output logic line_out
);
  initial line_out = 1'b1;

  // Each pulse is w cycles low then w high, far below the shutdown delay.
  task automatic pulses(input int n, input int w);
    for (int i = 0; i < n; i++) begin
      line_out <= 1'b0;
      repeat (w) @(posedge clk_in);
      line_out <= 1'b1;
      repeat (w) @(posedge clk_in);
    end
  endtask

  task automatic level(input logic v);
    line_out <= v;
  endtask
endmodule

`default_nettype wire

// ===== sim/tb_pulse_count_amp_config.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module tb_pulse_count_amp_config
  import pcac_pkg::*;
  ();
  localparam int SD = 40;
  localparam int VD = 20;
  localparam int WK = 50;
  localparam int ATK = 4;
  localparam int HLD = 16;
  localparam int REL = 8;
  localparam pcac_cfg_t DEF = '{1'b1, 1'b1, 1'b1, 3'h0, 3'h7};

  int compares = 0;
  int miscompares = 0;
  int seed = 32070;
  int t = 0;
  int t_dec = -1000;
  int t_inc = -1000;
  logic [3:0] prev_at = 4'h0;
  pcac_cfg_t exp_c;
  pcac_cfg_t obs;
  logic clk_in, resetn_in, config_line, clip_near_in, headroom_in, over_current_in;
  logic agc_en_out, limit_en_out, gain18_out, amp_on_out, bridge_hiz_out;
  logic [2:0] thd_sel_out, plim_sel_out;
  logic [3:0] atten_out, s_axi_wstrb;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;

  assign obs = {agc_en_out, limit_en_out, gain18_out, thd_sel_out, plim_sel_out};

  pcac_top #(.SD_CYC(SD), .VALID_CYC(VD), .WAKE_CYC(WK), .ATTACK_CYC(ATK), .HOLD_CYC(HLD),
    .RELEASE_CYC(REL)) dut_u (
    .clk_in(clk_in), .resetn_in(resetn_in), .config_line_in(config_line),
    .clip_near_in(clip_near_in), .headroom_in(headroom_in), .over_current_in(over_current_in),
    .agc_en_out(agc_en_out), .limit_en_out(limit_en_out), .gain18_out(gain18_out),
    .thd_sel_out(thd_sel_out), .plim_sel_out(plim_sel_out), .atten_out(atten_out),
    .amp_on_out(amp_on_out), .bridge_hiz_out(bridge_hiz_out),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );

  pcac_host host_u (.clk_in(clk_in), .line_out(config_line));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic results();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wt(input int c);
    repeat (c) @(posedge clk_in);
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge clk_in);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        return;
      end
    end
    miscompares++;
    results();
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge clk_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge clk_in);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        return;
      end
    end
    miscompares++;
    results();
  endtask

  function automatic pcac_cfg_t exp_cfg(input pcac_cfg_t c, input int n);
    pcac_cfg_t r;
    r = c;
    if (n == 1 || n == 2) r.agc_en = (n == 2);
    else if (n == 3) r = DEF;
    else if (n == 4 || n == 5) r.gain18 = (n == 5);
    else if (n >= 6 && n <= 13) r.thd = 3'(n - 6);
    else if (n == 14 || n == 15) r.limit_en = (n == 14);
    else if (n >= 16 && n <= 23) r.plim = 3'(n - 16);
    return r;
  endfunction

  // Spacing of gain steps; raises are only judged while headroom is offered.
  always @(posedge clk_in) begin
    if (atten_out > prev_at) begin
      `CHK(t - t_dec >= ATK, 1'b1)
      t_dec = t;
    end else if (atten_out < prev_at && headroom_in === 1'b1) begin
      `CHK(t - t_dec >= HLD, 1'b1)
      `CHK(t - t_inc >= REL, 1'b1)
      t_inc = t;
    end
    prev_at = atten_out;
    t++;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int n;
    int w;
    resetn_in <= 1'b0;
    clip_near_in <= 1'b0;
    headroom_in <= 1'b0;
    over_current_in <= 1'b0;
    s_axi_awaddr <= 8'h00;
    s_axi_araddr <= 8'h00;
    s_axi_wdata <= 32'h0;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    exp_c = DEF;
    wt(12);
    resetn_in <= 1'b1;
    wt(2);
    `CHK(obs, DEF)
    axr(8'h00);
    `CHK(rd[15:0], {3'b001, 4'h0, DEF})
    axr(8'h04);
    `CHK(rd[3:0], 4'hf)
    axw(8'h04, 32'h2);
    axr(8'h04);
    `CHK(rd[3:0], 4'h2)
    s_axi_wstrb <= 4'he;
    axw(8'h04, 32'h9);
    axr(8'h04);
    `CHK(rd[3:0], 4'h2)
    s_axi_wstrb <= 4'hf;
    axw(8'h00, 32'hffff);
    `CHK(rs, 2'b00)
    axr(8'h00);
    `CHK(rd[8:0], DEF)
    axw(8'h40, 32'h5);
    `CHK(rs, 2'b10)
    axr(8'h40);
    `CHK({rs, rd}, {2'b10, 32'h0})
    for (int i = 0; i < 56; i++) begin
      n = (i < 27) ? i : {$random(seed)} % 27;
      w = 1 + {$random(seed)} % 3;
      exp_c = exp_cfg(exp_c, n);
      host_u.pulses(n, w);
      wt(VD + 4);
      `CHK(obs, exp_c)
    end
    host_u.pulses(5, 1);
    wt(VD + 4);
    exp_c = exp_cfg(exp_c, 5);
    axr(8'h08);
    `CHK(rd[5:0], 6'h05)
    host_u.pulses(2, 2);
    wt(VD + 4);
    exp_c = exp_cfg(exp_c, 2);
    clip_near_in <= 1'b1;
    wt(3 * ATK + 10);
    `CHK(atten_out, 4'h2)
    clip_near_in <= 1'b0;
    headroom_in <= 1'b1;
    wt(HLD + 2 * REL + 10);
    `CHK(atten_out, 4'h0)
    headroom_in <= 1'b0;
    host_u.pulses(1, 2);
    wt(VD + 4);
    exp_c = exp_cfg(exp_c, 1);
    clip_near_in <= 1'b1;
    wt(3 * ATK + 10);
    `CHK(atten_out, 4'h0)
    clip_near_in <= 1'b0;
    over_current_in <= 1'b1;
    wt(3);
    `CHK(bridge_hiz_out, 1'b1)
    over_current_in <= 1'b0;
    wt(3);
    `CHK(bridge_hiz_out, 1'b0)
    host_u.pulses(2, 1);
    wt(VD + 4);
    host_u.level(1'b0);
    wt(SD - 10);
    host_u.level(1'b1);
    wt(VD + 4);
    exp_c = exp_cfg(exp_c, 1);
    `CHK({amp_on_out, obs}, {1'b1, exp_c})
    host_u.pulses(4, 1);
    wt(VD + 4);
    exp_c = exp_cfg(exp_c, 4);
    `CHK(obs, exp_c)
    host_u.level(1'b0);
    wt(SD + 3);
    `CHK({amp_on_out, bridge_hiz_out}, 2'b01)
    host_u.level(1'b1);
    wt(WK - 10);
    `CHK({amp_on_out, bridge_hiz_out}, 2'b01)
    wt(15);
    `CHK(amp_on_out, 1'b1)
    `CHK(obs, DEF)
    results();
  end
endmodule

`default_nettype wire
